// ### apc_debounce.sv
/*
 * apc_debounce: filters one button and gives a level and a press pulse.
 * Assumes a one-cycle tick enable from the shared timebase.
 */
`timescale 1ns/1ps
`default_nettype none
module apc_debounce #(
    parameter int STABLE_TICKS = 10
) (
    input wire logic clk_in, // system clock
    input wire logic rst_in, // sync reset
    input wire logic tick_in, // timebase tick
    input wire logic raw_in, // raw button
    output logic level_out, // filtered level
    output logic press_out // one-cycle press pulse
);
    import apc_pkg::*;
    initial begin
        if (STABLE_TICKS < 1 || STABLE_TICKS > 255)
            $error("apc_debounce: STABLE_TICKS out of range");
    end

    logic [7:0] cnt_q;
    logic lvl_q;
    logic prs_q;

    // accept a new level only after it stays for the full window
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cnt_q <= 8'h00;
            lvl_q <= 1'b0;
            prs_q <= 1'b0;
        end else begin
            prs_q <= 1'b0;
            if (raw_in == lvl_q) begin
                cnt_q <= 8'h00;
            end else if (tick_in) begin
                if (cnt_q == 8'(STABLE_TICKS - 1)) begin
                    cnt_q <= 8'h00;
                    lvl_q <= raw_in;
                    prs_q <= raw_in;
                end else begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end
        end
    end
    assign level_out = lvl_q;
    assign press_out = prs_q;
endmodule
`default_nettype wire

// ### apc_meter.sv
/*
 * apc_meter: one elapsed-time meter with seconds and a cycle count.
 * Assumes a one-second enable and a one-cycle start pulse.
 */
`timescale 1ns/1ps
`default_nettype none
module apc_meter #(
    parameter int SEC_W = 32,
    parameter int CYC_W = 24
) (
    input wire logic clk_in, // system clock
    input wire logic rst_in, // sync reset
    input wire logic sec_in, // one-second enable
    input wire logic run_in, // meter runs
    input wire logic start_in, // cycle start pulse
    output logic [SEC_W-1:0] secs_out, // total seconds
    output logic [CYC_W-1:0] cycles_out // cycle count
);
    import apc_pkg::*;
    initial begin
        if (SEC_W < 17 || CYC_W < 1)
            $error("apc_meter: widths too small");
    end

    // counters saturate instead of wrapping to zero
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            secs_out <= '0;
        end else if (sec_in && run_in && ~&secs_out) begin
            secs_out <= secs_out + SEC_W'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cycles_out <= '0;
        end else if (start_in && ~&cycles_out) begin
            cycles_out <= cycles_out + CYC_W'(1);
        end
    end
endmodule
`default_nettype wire

// ### apc_panel.sv
/*
 * apc_panel: operating state, menu, interlock and control-mode logic
 * of an RF power amplifier front panel.
 * Assumes buttons, interlock and bus commands are synchronous to
 * REF_CLK_IN; bus command inputs are one-cycle pulses.
 */
// What this block does
// [RULE_01] model screen, main screen after 2 s
// [RULE_02] after boot: standby, local, local shown
// [RULE_03] menu entry needs one-second two-button hold
// [RULE_04] four menu pages, hold advances, then main
// [RULE_05] supply page clicks step supply channel
// [RULE_06] count operate time and RF cycles
// [RULE_07] meter page clicks step three meters
// [RULE_08] address page clicks change 01..31, default 07
// [RULE_09] refuse activation on interlock error/open
// [RULE_10] loop open drops to standby, no auto-restart
// [RULE_11] key in standby enters operate, RF on
// [RULE_12] key in operate turns RF off
// [RULE_13] fan runs one minute after deactivation
// [RULE_14] status lamp lights on shutdown fault
// [RULE_15] bus remote command sets remote state
// [RULE_16] control mode changes only in standby
// [RULE_17] go-to-local command returns local control
// [RULE_18] control key returns local control
// [RULE_19] fault latched until standby key confirms
// [RULE_20] address change takes effect at once
// [RULE_21] debounced buttons, hold timed by timebase
`timescale 1ns/1ps
`default_nettype none
module apc_panel #(
    parameter int TICK_CYCLES = apc_pkg::TICK_CYC,
    parameter int CH_W = 3,
    parameter logic [CH_W-1:0] CH_LAST = 3'h7
) (
    input wire logic REF_CLK_IN, // system clock
    input wire logic RST_IN, // mains power-up reset
    input wire logic BTN_LEFT_IN, // left button
    input wire logic BTN_RIGHT_IN, // right button
    input wire logic KEY_OPER_IN, // standby/operate key
    input wire logic KEY_CTRL_IN, // control key
    input wire logic LOOP_CLOSED_IN, // interlock loop closed
    input wire logic BUS_REMOTE_IN, // remote command pulse
    input wire logic BUS_GTL_IN, // go-to-local pulse
    input wire logic BUS_OPER_IN, // remote activate pulse
    input wire logic BUS_STBY_IN, // remote standby pulse
    input wire logic [1:0] BAND_IN, // current frequency band
    output apc_pkg::apc_screen_t SCREEN_OUT, // shown screen
    output apc_pkg::apc_text_t TEXT_OUT, // main status text
    output apc_pkg::apc_ctl_t CTL_OUT, // control source
    output logic RF_ON_OUT, // RF enabled
    output logic FAN_OUT, // cooling fan on
    output logic LED_FAULT_OUT, // status led
    output logic [CH_W-1:0] CHAN_OUT, // supply channel shown
    output logic [1:0] METER_OUT, // meter shown
    output logic [4:0] ADDR_OUT, // bus address
    output logic [31:0] MAINS_SECS_OUT, // mains-on seconds
    output logic [31:0] OPER_SECS_OUT, // operate seconds
    output logic [31:0] BAND_SECS_OUT, // band 0 operate seconds
    output logic [23:0] CYCLES_OUT // RF on cycles
);
    import apc_pkg::*;
    initial begin
        if (TICK_CYCLES < 1 || TICK_CYCLES > 1_000_000 || CH_W < 1)
            $error("apc_panel: bad parameter");
    end

    ////////////////////////////////////////////////////////////////////
    // timebase

    logic [19:0] tick_cnt_q;
    logic tick;
    logic [9:0] ms_cnt_q;
    logic sec_tick;

    // free-running millisecond tick [RULE_21]
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN || tick)
            tick_cnt_q <= 20'h00000;
        else
            tick_cnt_q <= tick_cnt_q + 20'h00001;
    end
    assign tick = (tick_cnt_q == 20'(TICK_CYCLES - 1));

    // second tick for the meters
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN)
            ms_cnt_q <= 10'h000;
        else if (tick)
            ms_cnt_q <= sec_tick ? 10'h000 : ms_cnt_q + 10'h001;
    end
    assign sec_tick = tick && (ms_cnt_q == 10'(SEC_MS - 1));

    ////////////////////////////////////////////////////////////////////
    // button filtering

    logic lft_lvl, lft_prs, rgt_lvl, rgt_prs;
    logic opk_prs, ctk_prs;

    apc_debounce #(.STABLE_TICKS(DEB_MS)) u_left (
        .clk_in(REF_CLK_IN), .rst_in(RST_IN), .tick_in(tick),
        .raw_in(BTN_LEFT_IN), .level_out(lft_lvl), .press_out(lft_prs));
    apc_debounce #(.STABLE_TICKS(DEB_MS)) u_right (
        .clk_in(REF_CLK_IN), .rst_in(RST_IN), .tick_in(tick),
        .raw_in(BTN_RIGHT_IN), .level_out(rgt_lvl), .press_out(rgt_prs));
    apc_debounce #(.STABLE_TICKS(DEB_MS)) u_oper (
        .clk_in(REF_CLK_IN), .rst_in(RST_IN), .tick_in(tick),
        .raw_in(KEY_OPER_IN), .level_out(), .press_out(opk_prs));
    apc_debounce #(.STABLE_TICKS(DEB_MS)) u_ctrl (
        .clk_in(REF_CLK_IN), .rst_in(RST_IN), .tick_in(tick),
        .raw_in(KEY_CTRL_IN), .level_out(), .press_out(ctk_prs));

    ////////////////////////////////////////////////////////////////////
    // two-button hold and single clicks

    logic [10:0] hold_q;
    logic hold_done_q;
    logic both;
    logic hold_evt;
    logic click_l, click_r;

    // a press while the other is held, or in the same cycle, belongs
    // to the hold, not a click; else a menu exit would step the page
    assign both = lft_lvl && rgt_lvl;
    assign click_l = lft_prs && !rgt_lvl && !rgt_prs;
    assign click_r = rgt_prs && !lft_lvl && !lft_prs;

    // one event per hold; release either button to arm the next [RULE_03]
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN || !both) begin
            hold_q <= 11'h000;
            hold_done_q <= 1'b0;
        end else if (tick && !hold_done_q) begin
            if (hold_q == 11'(HOLD_MS - 1))
                hold_done_q <= 1'b1;
            else
                hold_q <= hold_q + 11'h001;
        end
    end
    assign hold_evt = both && tick && !hold_done_q
                      && hold_q == 11'(HOLD_MS - 1); // [RULE_21]

    ////////////////////////////////////////////////////////////////////
    // screens

    apc_screen_t scr_q;
    logic [10:0] boot_q;

    // boot timer held at the model screen [RULE_01]
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN)
            boot_q <= 11'h000;
        else if (scr_q == SCR_MODEL && tick)
            boot_q <= boot_q + 11'h001;
    end

    // menu walk: main, supply, ident, meter, address, main [RULE_04]
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            scr_q <= SCR_MODEL;
        end else begin
            case (scr_q)
                SCR_MODEL: if (tick && boot_q == 11'(BOOT_MS - 1))
                    scr_q <= SCR_MAIN; // [RULE_01]
                SCR_MAIN: if (hold_evt) scr_q <= SCR_SUPPLY; // [RULE_03]
                SCR_SUPPLY: if (hold_evt) scr_q <= SCR_IDENT;
                SCR_IDENT: if (hold_evt) scr_q <= SCR_METER;
                SCR_METER: if (hold_evt) scr_q <= SCR_ADDR;
                SCR_ADDR: if (hold_evt) scr_q <= SCR_MAIN; // [RULE_04]
                default: scr_q <= SCR_MAIN;
            endcase
        end
    end

    // supply channel stepping wraps at both ends [RULE_05]
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN)
            CHAN_OUT <= '0;
        else if (scr_q == SCR_SUPPLY && click_r)
            CHAN_OUT <= (CHAN_OUT == CH_LAST) ? '0 : CHAN_OUT + CH_W'(1);
        else if (scr_q == SCR_SUPPLY && click_l)
            CHAN_OUT <= (CHAN_OUT == '0) ? CH_LAST : CHAN_OUT - CH_W'(1);
    end

    // meter selection: mains, operate, band [RULE_07]
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN)
            METER_OUT <= 2'h0;
        else if (scr_q == SCR_METER && click_r)
            METER_OUT <= (METER_OUT == METER_LAST) ? 2'h0 : METER_OUT + 2'h1;
        else if (scr_q == SCR_METER && click_l)
            METER_OUT <= (METER_OUT == 2'h0) ? METER_LAST : METER_OUT - 2'h1;
    end

    // address used live, no confirm step; clamps at limits [RULE_08]
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN)
            ADDR_OUT <= ADDR_RST;
        else if (scr_q == SCR_ADDR && click_r && ADDR_OUT != ADDR_MAX)
            ADDR_OUT <= ADDR_OUT + 5'h01; // [RULE_20]
        else if (scr_q == SCR_ADDR && click_l && ADDR_OUT != ADDR_MIN)
            ADDR_OUT <= ADDR_OUT - 5'h01; // [RULE_20]
    end

    ////////////////////////////////////////////////////////////////////
    // operating state, interlock and faults

    logic booted;
    logic fault_q;
    logic rf_q;
    logic req_on, req_off;
    logic activate, drop;
    apc_text_t txt_q;

    assign booted = (scr_q != SCR_MODEL);
    // requests from the source in control only
    assign req_on = booted && ((CTL_OUT == CTL_LOCAL && opk_prs)
                    || (CTL_OUT == CTL_BUS && BUS_OPER_IN));
    assign req_off = (CTL_OUT == CTL_LOCAL && opk_prs)
                     || (CTL_OUT == CTL_BUS && BUS_STBY_IN);
    // loop open or latched fault blocks activation [RULE_09]
    assign activate = !rf_q && req_on && !fault_q && LOOP_CLOSED_IN;
    assign drop = rf_q && !LOOP_CLOSED_IN; // [RULE_10]

    // latched interlock fault; a local key press confirms it [RULE_19]
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN)
            fault_q <= 1'b0;
        else if (!LOOP_CLOSED_IN && booted)
            fault_q <= 1'b1; // set wins over the confirm
        else if (opk_prs && !rf_q)
            fault_q <= 1'b0;
    end

    // rf state: reclosing the loop never restarts it [RULE_10]
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN)
            rf_q <= 1'b0; // [RULE_02]
        else if (drop)
            rf_q <= 1'b0;
        else if (activate)
            rf_q <= 1'b1; // [RULE_11]
        else if (rf_q && req_off)
            rf_q <= 1'b0; // [RULE_12]
    end

    // status text follows the rf state and faults
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN)
            txt_q <= TXT_STANDBY;
        else if (drop || (fault_q && !rf_q && !(opk_prs && LOOP_CLOSED_IN)))
            txt_q <= TXT_INTERLOCK; // [RULE_10]
        else if (activate)
            txt_q <= TXT_OPERATE; // [RULE_11]
        else if (rf_q && req_off)
            txt_q <= TXT_RF_OFF; // [RULE_12]
        else if (txt_q == TXT_INTERLOCK)
            txt_q <= TXT_STANDBY;
    end

    assign RF_ON_OUT = rf_q;
    assign TEXT_OUT = txt_q;
    assign SCREEN_OUT = scr_q;
    assign LED_FAULT_OUT = fault_q; // [RULE_14]

    ////////////////////////////////////////////////////////////////////
    // fan run-on

    logic [15:0] fan_q;

    // keeps cooling for a minute after rf drops [RULE_13]
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN)
            fan_q <= 16'h0000;
        else if (rf_q)
            fan_q <= 16'(FAN_MS);
        else if (tick && fan_q != 16'h0000)
            fan_q <= fan_q - 16'h0001;
    end
    assign FAN_OUT = rf_q || (fan_q != 16'h0000);

    ////////////////////////////////////////////////////////////////////
    // control mode

    // mode changes ignored while operating [RULE_16]
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN)
            CTL_OUT <= CTL_LOCAL; // [RULE_02]
        else if (!rf_q && (BUS_GTL_IN || ctk_prs))
            CTL_OUT <= CTL_LOCAL; // [RULE_17] [RULE_18]
        else if (!rf_q && BUS_REMOTE_IN)
            CTL_OUT <= CTL_BUS; // [RULE_15]
    end

    ////////////////////////////////////////////////////////////////////
    // elapsed time meters

    logic cyc_start;
    assign cyc_start = activate;

    // mains-on, operate (with cycles), and band 0 operate time [RULE_06]
    apc_meter u_mains (
        .clk_in(REF_CLK_IN), .rst_in(RST_IN), .sec_in(sec_tick),
        .run_in(1'b1), .start_in(1'b0),
        .secs_out(MAINS_SECS_OUT), .cycles_out());
    apc_meter u_oper_m (
        .clk_in(REF_CLK_IN), .rst_in(RST_IN), .sec_in(sec_tick),
        .run_in(rf_q), .start_in(cyc_start),
        .secs_out(OPER_SECS_OUT), .cycles_out(CYCLES_OUT));
    apc_meter u_band (
        .clk_in(REF_CLK_IN), .rst_in(RST_IN), .sec_in(sec_tick),
        .run_in(rf_q && BAND_IN == 2'h0), .start_in(1'b0),
        .secs_out(BAND_SECS_OUT), .cycles_out());

    ////////////////////////////////////////////////////////////////////
    // checks

    sequence loop_opens_s;
        rf_q && !LOOP_CLOSED_IN;
    endsequence

    interlock_drop_a: assert property (@(posedge REF_CLK_IN) // [RULE_10]
        disable iff (RST_IN) loop_opens_s |=> !rf_q && txt_q == TXT_INTERLOCK)
        else $error("rf not dropped on open loop");
    no_activate_fault_a: assert property (@(posedge REF_CLK_IN) // [RULE_09]
        disable iff (RST_IN) (!LOOP_CLOSED_IN || fault_q) && !rf_q |=> !rf_q)
        else $error("activated with interlock fault");
    key_operate_a: assert property (@(posedge REF_CLK_IN) // [RULE_11]
        disable iff (RST_IN) activate |=> rf_q && txt_q == TXT_OPERATE)
        else $error("key did not start operate");
    key_rf_off_a: assert property (@(posedge REF_CLK_IN) // [RULE_12]
        disable iff (RST_IN) rf_q && req_off && LOOP_CLOSED_IN
        |=> !rf_q && txt_q == TXT_RF_OFF)
        else $error("rf off not shown");
    mode_hold_a: assert property (@(posedge REF_CLK_IN) // [RULE_16]
        disable iff (RST_IN) rf_q |=> $stable(CTL_OUT))
        else $error("mode changed while operating");
    fan_runon_a: assert property (@(posedge REF_CLK_IN) // [RULE_13]
        disable iff (RST_IN) $fell(rf_q) |-> FAN_OUT [*8])
        else $error("fan stopped early");
    addr_range_a: assert property (@(posedge REF_CLK_IN) // [RULE_08]
        disable iff (RST_IN) ADDR_OUT >= ADDR_MIN && ADDR_OUT <= ADDR_MAX)
        else $error("address out of range");
    menu_exit_a: assert property (@(posedge REF_CLK_IN) // [RULE_04]
        disable iff (RST_IN) scr_q == SCR_ADDR && hold_evt
        |=> scr_q == SCR_MAIN)
        else $error("menu did not return to main");
    led_fault_a: assert property (@(posedge REF_CLK_IN) // [RULE_14]
        disable iff (RST_IN) drop |=> LED_FAULT_OUT)
        else $error("status led dark after shutdown");
    remote_set_a: assert property (@(posedge REF_CLK_IN) // [RULE_15]
        disable iff (RST_IN) BUS_REMOTE_IN && !rf_q && !BUS_GTL_IN
        && !ctk_prs |=> CTL_OUT == CTL_BUS)
        else $error("remote command ignored");
endmodule
`default_nettype wire

// ### apc_partner.sv
/*
 * apc_partner: front-panel user and bus controller for apc_panel.
 * Assumes one clock; key holds are given in timebase ticks of TICK cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module apc_partner #(
    parameter int TICK = 4
) (
    input wire logic clk_in, // system clock
    output logic [3:0] btn_out, // ctrl, oper, right, left
    output logic loop_out, // interlock loop closed
    output logic [3:0] bus_out // stby, oper, gtl, remote
);
    ////////////////////////////////////////////////////////////////////
    // idle: nothing pressed, loop closed, no bus command
    initial begin
        btn_out = 4'h0;
        loop_out = 1'b1;
        bus_out = 4'h0;
    end
    // press keys for some ticks; the release wait outlasts the filter
    task automatic press(input logic [3:0] m, input int ticks);
        @(posedge clk_in);
        btn_out <= m;
        repeat (ticks * TICK) @(posedge clk_in);
        btn_out <= 4'h0;
        repeat (15 * TICK) @(posedge clk_in);
    endtask
    // one-cycle bus command, as the controller issues it
    task automatic pulse(input int sel);
        @(posedge clk_in);
        bus_out[sel] <= 1'b1;
        @(posedge clk_in);
        bus_out <= 4'h0;
        repeat (3) @(posedge clk_in);
    endtask
    // loop line has no filter, so a few cycles settle it
    task automatic loop(input logic c);
        @(posedge clk_in);
        loop_out <= c;
        repeat (3) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

// ### apc_pkg.sv
/*
 * apc_pkg: shared constants and types for the amplifier panel control.
 * Assumes a 250 MHz single clock; all timing counts derive from it.
 */
package apc_pkg;
    // clock rate in hertz
    localparam longint CLK_HZ = 250_000_000;
    // timebase tick: one millisecond
    localparam int TICK_US = 1000;
    localparam int TICK_CYC = int'((CLK_HZ / 1_000_000) * TICK_US);
    // timing constants, in milliseconds
    localparam int BOOT_MS = 2000;
    localparam int HOLD_MS = 1000;
    localparam int FAN_MS = 60000;
    localparam int DEB_MS = 10;
    localparam int SEC_MS = 1000;
    // bus address limits and default
    localparam logic [4:0] ADDR_MIN = 5'h01;
    localparam logic [4:0] ADDR_MAX = 5'h1f;
    localparam logic [4:0] ADDR_RST = 5'h07;
    // last elapsed-time meter selection index
    localparam logic [1:0] METER_LAST = 2'h2;

    // display screens
    typedef enum logic [2:0] {
        SCR_MODEL, SCR_MAIN, SCR_SUPPLY, SCR_IDENT, SCR_METER, SCR_ADDR
    } apc_screen_t;

    // control source
    typedef enum logic [1:0] {
        CTL_LOCAL, CTL_BUS
    } apc_ctl_t;

    // main status text
    typedef enum logic [1:0] {
        TXT_STANDBY, TXT_OPERATE, TXT_RF_OFF, TXT_INTERLOCK
    } apc_text_t;
endpackage

// ### testbench.sv
/*
 * testbench: self-checking bench for apc_panel with a shortened tick.
 * Assumes apc_pkg and apc_partner are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
    n_checks++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
end
module testbench;
    import apc_pkg::*;
    localparam int TK = 4;
    localparam int LIMIT = 90000;
    typedef struct {int id; logic [31:0] v;} apc_note_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] band = 2'h0;
    logic [3:0] btn;
    logic [3:0] bus;
    logic loop_c;
    apc_screen_t scr;
    apc_text_t txt;
    apc_ctl_t ctl;
    logic rf;
    logic fan;
    logic led;
    logic [2:0] chan;
    logic [1:0] met;
    logic [4:0] addr;
    logic [31:0] mains_s;
    logic [31:0] oper_s;
    logic [31:0] band_s;
    logic [23:0] cyc;
    apc_note_t notes[$];
    apc_note_t cur;
    logic [31:0] aux = 32'h0;
    logic [31:0] os;
    int n_errors = 0;
    int n_checks = 0;
    int ncyc = 0;
    int tmo = 0;
    event chk_ev;

    ////////////////////////////////////////////////////////////////////
    // clock, 4 ns period
    initial begin
        forever #2 clk = ~clk;
    end
    apc_partner #(.TICK(TK)) u_apc_partner (.clk_in(clk), .btn_out(btn),
        .loop_out(loop_c), .bus_out(bus));
    apc_panel #(.TICK_CYCLES(TK)) u_apc_panel (.REF_CLK_IN(clk),
        .RST_IN(rst), .BTN_LEFT_IN(btn[0]), .BTN_RIGHT_IN(btn[1]),
        .KEY_OPER_IN(btn[2]), .KEY_CTRL_IN(btn[3]),
        .LOOP_CLOSED_IN(loop_c), .BUS_REMOTE_IN(bus[0]),
        .BUS_GTL_IN(bus[1]), .BUS_OPER_IN(bus[2]), .BUS_STBY_IN(bus[3]),
        .BAND_IN(band), .SCREEN_OUT(scr), .TEXT_OUT(txt), .CTL_OUT(ctl),
        .RF_ON_OUT(rf), .FAN_OUT(fan), .LED_FAULT_OUT(led),
        .CHAN_OUT(chan), .METER_OUT(met), .ADDR_OUT(addr),
        .MAINS_SECS_OUT(mains_s), .OPER_SECS_OUT(oper_s),
        .BAND_SECS_OUT(band_s), .CYCLES_OUT(cyc));

    ////////////////////////////////////////////////////////////////////
    // observed value by note id; 10 is a bench-computed flag
    function automatic logic [31:0] obs(input int id);
        case (id)
            0: return 32'(scr);
            1: return 32'(txt);
            2: return 32'(ctl);
            3: return {31'h0, rf};
            4: return {31'h0, fan};
            5: return {31'h0, led};
            6: return {29'h0, chan};
            7: return {30'h0, met};
            8: return {27'h0, addr};
            9: return {8'h0, cyc};
            default: return aux;
        endcase
    endfunction
    // watcher: each check event drains the oldest notes in order
    always @(chk_ev) begin
        while (notes.size() > 0) begin
            cur = notes.pop_front();
            `CHK(obs(cur.id), cur.v)
        end
    end
    task automatic note(input int id, input logic [31:0] v);
        notes.push_back('{id, v});
    endtask
    // outputs are compared 1 ns after the edge, once registers settled
    task automatic settle();
        #1 ->chk_ev;
    endtask
    task automatic st(input logic [31:0] t, input logic [31:0] r,
                      input logic [31:0] l);
        note(1, t);
        note(3, r);
        note(5, l);
        settle();
    endtask
    function automatic int hold();
        return 12 + int'($urandom_range(20));
    endfunction
    task automatic finish_test();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // hang guard sized well above the whole sequence
    always @(posedge clk) begin
        tmo <= tmo + 1;
        if (tmo == LIMIT) begin
            n_errors++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        void'($urandom(27112));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        band <= 2'($urandom_range(3));
        repeat (1990 * TK) @(posedge clk);
        note(0, SCR_MODEL);
        settle();
        repeat (20 * TK) @(posedge clk);
        note(0, SCR_MAIN);
        note(2, CTL_LOCAL);
        note(8, ADDR_RST);
        st(TXT_STANDBY, 0, 0);
        // local activation, a refused mode change, then RF off
        u_apc_partner.press(4'h4, hold());
        ncyc++;
        note(9, ncyc);
        note(4, 1);
        st(TXT_OPERATE, 1, 0);
        u_apc_partner.pulse(0);
        note(2, CTL_LOCAL);
        settle();
        u_apc_partner.press(4'h4, hold());
        note(4, 1);
        st(TXT_RF_OFF, 0, 0);
        // trip the loop while operating; the fault must stay latched
        u_apc_partner.press(4'h4, hold());
        ncyc++;
        u_apc_partner.loop(0);
        st(TXT_INTERLOCK, 0, 1);
        u_apc_partner.press(4'h4, hold());
        st(TXT_INTERLOCK, 0, 1);
        u_apc_partner.loop(1);
        st(TXT_INTERLOCK, 0, 1);
        u_apc_partner.press(4'h4, hold());
        st(TXT_STANDBY, 0, 0);
        // about three seconds of operate time
        os = oper_s;
        u_apc_partner.press(4'h4, hold());
        ncyc++;
        note(9, ncyc);
        st(TXT_OPERATE, 1, 0);
        repeat (3000 * TK) @(posedge clk);
        u_apc_partner.press(4'h4, hold());
        aux = {31'h0, (oper_s - os) inside {[32'h3:32'h4]}};
        note(10, 1);
        settle();
        // remote control, bus activation, then a go-to-local refused while operating
        u_apc_partner.pulse(0);
        note(2, CTL_BUS);
        settle();
        u_apc_partner.pulse(2);
        ncyc++;
        note(9, ncyc);
        st(TXT_OPERATE, 1, 0);
        u_apc_partner.pulse(1);
        note(2, CTL_BUS);
        settle();
        // remote standby, then remote activation again
        u_apc_partner.pulse(3);
        st(TXT_RF_OFF, 0, 0);
        u_apc_partner.pulse(2);
        ncyc++;
        note(9, ncyc);
        st(TXT_OPERATE, 1, 0);
        u_apc_partner.loop(0);
        u_apc_partner.loop(1);
        u_apc_partner.pulse(2);
        st(TXT_INTERLOCK, 0, 1);
        u_apc_partner.pulse(1);
        note(2, CTL_LOCAL);
        settle();
        u_apc_partner.press(4'h4, hold());
        st(TXT_STANDBY, 0, 0);
        u_apc_partner.pulse(0);
        u_apc_partner.press(4'h8, hold());
        note(2, CTL_LOCAL);
        settle();
        // menu: a short hold is not enough, then walk all four pages
        u_apc_partner.press(4'h3, 900);
        note(0, SCR_MAIN);
        settle();
        u_apc_partner.press(4'h3, 1100);
        note(0, SCR_SUPPLY);
        note(6, 0);
        settle();
        u_apc_partner.press(4'h1, hold());
        note(6, 7);
        settle();
        u_apc_partner.press(4'h2, 3);
        note(6, 7);
        settle();
        u_apc_partner.press(4'h2, hold());
        u_apc_partner.press(4'h2, hold());
        note(6, 1);
        settle();
        u_apc_partner.press(4'h3, 1100);
        note(0, SCR_IDENT);
        settle();
        u_apc_partner.press(4'h3, 1100);
        note(0, SCR_METER);
        settle();
        for (int i = 1; i <= 3; i++) begin
            u_apc_partner.press(4'h2, hold());
            note(7, i % 3);
            settle();
        end
        u_apc_partner.press(4'h1, hold());
        note(7, 2);
        settle();
        u_apc_partner.press(4'h3, 1100);
        note(0, SCR_ADDR);
        settle();
        u_apc_partner.press(4'h2, hold());
        note(8, 8);
        settle();
        // drive past both ends of the address range
        repeat (9) u_apc_partner.press(4'h1, hold());
        note(8, 1);
        settle();
        repeat (31) u_apc_partner.press(4'h2, hold());
        note(8, 31);
        settle();
        u_apc_partner.press(4'h3, 1100);
        note(0, SCR_MAIN);
        settle();
        // mains meter tracks run time; band meter counts band 0 only
        aux = {31'h0, (32'(tmo / (SEC_MS * TK)) - mains_s) <= 32'h1};
        note(10, 1);
        settle();
        aux = {31'h0, band_s == ((band == 2'h0) ? oper_s : 32'h0)};
        note(10, 1);
        settle();
        repeat (4) @(posedge clk);
        finish_test();
    end
endmodule
`default_nettype wire
